/* rtl/mda_map.svh */
`ifndef MDA_MAP_SVH
`define MDA_MAP_SVH

// Number of requesting channels.
`define MDA_NUM_CH 8
// Width of the pin synchroniser: requests, hold grant, ready, direction.
`define MDA_SYNC_W 11
// Reset value of the active-low grant outputs.
`define MDA_GRANT_N_RST 8'hFF
// Reset value of the active-low strobes.
`define MDA_STROBE_N_RST 1'h1
// Reset value of the synchroniser stages.
`define MDA_SYNC_RST 11'h000
`endif

/* rtl/mda_pkg.sv */
package mda_pkg;
  // Memory cycle sequencer, Gray coded along idle, first, wait, final.
  typedef enum logic [1:0] {
    MDA_CYC_IDLE  = 2'h0,
    MDA_CYC_FIRST = 2'h1,
    MDA_CYC_WAIT  = 2'h3,
    MDA_CYC_FINAL = 2'h2
  } mda_cyc_t;
endpackage

/* rtl/mda_sync2.sv */
`include "mda_map.svh"
module mda_sync2 #(
  parameter int WIDTH = `MDA_SYNC_W
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_q;

  // The first stage is read only by the second stage.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      meta_q <= `MDA_SYNC_RST;
      dout <= `MDA_SYNC_RST;
    end
    else if (clk_en)
    begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule

/* rtl/mda_prio_sel.sv */
`include "mda_map.svh"
module mda_prio_sel #(
  parameter int N = `MDA_NUM_CH
) (
  input wire logic [N-1:0] req,
  output logic any_req,
  output logic [N-1:0] pick
);
  // Channel 0 has the highest priority. With no request the decoder
  // is disabled and pick is all zero.
  always_comb
  begin
    pick = '0;
    any_req = |req;
    for (int i = N - 1; i >= 0; i--)
    begin
      if (req[i])
      begin
        pick = '0;
        pick[i] = 1'b1;
      end
    end
  end
endmodule

/* rtl/mda_arbiter.sv */
`include "mda_map.svh"
module mda_arbiter (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [`MDA_NUM_CH-1:0] request_n,
  input wire logic cpu_bus_granted,
  input wire logic mem_ready,
  input wire logic read_direction,
  output logic [`MDA_NUM_CH-1:0] grant_n,
  output logic cycle_done_n,
  output logic hold_request_n,
  output logic memory_cycle_strobe_n,
  output logic write_strobe_n,
  output logic dma_cycle_flag_n
);
  logic [`MDA_NUM_CH-1:0] req_s;
  logic cpu_bus_granted_s;
  logic ready_s;
  logic rdir_s;
  logic any_request;
  logic [`MDA_NUM_CH-1:0] pick;

  logic acquire_q;
  logic acquire_d;
  logic ownership_q;
  logic ownership_d;
  logic giveback_q;
  logic giveback_d;
  mda_pkg::mda_cyc_t cyc_q;
  mda_pkg::mda_cyc_t cyc_d;
  logic first_st;
  logic wait_st;
  logic final_st;
  logic grant_load_enable;
  logic grant_load_pulse;
  logic hold_d;

  // Every request, ready and direction pin, the hold grant included, arrives from outside this
  // clock domain, so all of them pass two stages before use; reset and clock enable go straight in.
  mda_sync2 #(
    .WIDTH(`MDA_SYNC_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .din({~request_n, cpu_bus_granted, mem_ready, read_direction}),
    .dout({req_s, cpu_bus_granted_s, ready_s, rdir_s})
  );

  mda_prio_sel #(
    .N(`MDA_NUM_CH)
  ) u_prio (
    .req(req_s),
    .any_req(any_request),
    .pick(pick)
  );

  assign first_st = (cyc_q == mda_pkg::MDA_CYC_FIRST);
  assign wait_st = (cyc_q == mda_pkg::MDA_CYC_WAIT);
  assign final_st = (cyc_q == mda_pkg::MDA_CYC_FINAL);

  // Acquisition, ownership and giveback behave as J-K flip-flops.
  always_comb
  begin
    acquire_d = (any_request & ~ownership_q & ~giveback_q & ~acquire_q)
      | (acquire_q & ~cpu_bus_granted_s);
  end

  always_comb
  begin
    ownership_d = (cpu_bus_granted_s & acquire_q & ~ownership_q)
      | (ownership_q & ~(~any_request & final_st));
  end

  always_comb
  begin
    giveback_d = (~any_request & final_st & ~giveback_q)
      | (giveback_q & cpu_bus_granted_s);
  end

  // The hold pin is registered from the next state so that it shows the
  // same relation to the state flip-flops as the combinational form.
  always_comb
  begin
    hold_d = (any_request & ~giveback_d) | acquire_d | ownership_d;
  end

  always_comb
  begin
    cyc_d = cyc_q;
    unique case (cyc_q)
      mda_pkg::MDA_CYC_IDLE:
      begin
        if (cpu_bus_granted_s & acquire_q)
        begin
          cyc_d = mda_pkg::MDA_CYC_FIRST;
        end
      end
      mda_pkg::MDA_CYC_FIRST, mda_pkg::MDA_CYC_WAIT:
      begin
        if (ready_s)
        begin
          cyc_d = mda_pkg::MDA_CYC_FINAL;
        end
        else
        begin
          cyc_d = mda_pkg::MDA_CYC_WAIT;
        end
      end
      mda_pkg::MDA_CYC_FINAL:
      begin
        if (any_request)
        begin
          cyc_d = mda_pkg::MDA_CYC_FIRST;
        end
        else
        begin
          cyc_d = mda_pkg::MDA_CYC_IDLE;
        end
      end
    endcase
  end

  // Loading stays blocked during giveback: the processor may still show
  // its hold grant for a while after the hold request has gone.
  assign grant_load_enable = (cpu_bus_granted_s & acquire_q) | final_st;
  assign grant_load_pulse = grant_load_enable & ~giveback_q;

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      acquire_q <= 1'b0;
      ownership_q <= 1'b0;
      giveback_q <= 1'b0;
    end
    else if (clk_en)
    begin
      acquire_q <= acquire_d;
      ownership_q <= ownership_d;
      giveback_q <= giveback_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cyc_q <= mda_pkg::MDA_CYC_IDLE;
    end
    else if (clk_en)
    begin
      cyc_q <= cyc_d;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      grant_n <= `MDA_GRANT_N_RST;
    end
    else if (clk_en && grant_load_pulse)
    begin
      grant_n <= ~pick;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      hold_request_n <= `MDA_STROBE_N_RST;
      cycle_done_n <= `MDA_STROBE_N_RST;
      memory_cycle_strobe_n <= `MDA_STROBE_N_RST;
      dma_cycle_flag_n <= `MDA_STROBE_N_RST;
    end
    else if (clk_en)
    begin
      hold_request_n <= ~hold_d;
      cycle_done_n <= ~(cyc_d == mda_pkg::MDA_CYC_FINAL);
      memory_cycle_strobe_n <= (cyc_d == mda_pkg::MDA_CYC_IDLE);
      dma_cycle_flag_n <= ~((cyc_d == mda_pkg::MDA_CYC_FIRST)
        | (cyc_d == mda_pkg::MDA_CYC_WAIT));
    end
  end

  // The write strobe moves half a clock later than the rest, which
  // gives address and data setup before it falls.
  always_ff @(negedge ref_clk)
  begin
    if (rst)
    begin
      write_strobe_n <= `MDA_STROBE_N_RST;
    end
    else if (clk_en)
    begin
      write_strobe_n <= ~((~rdir_s & first_st)
        | (~write_strobe_n & wait_st));
    end
  end

  // Sampling only on enabled edges keeps every property in step with the
  // flip-flops, even when the enable drops for several clocks.
  default clocking cb @(posedge ref_clk iff clk_en);
  endclocking
  default disable iff (rst);

  sequence s_grant_take;
    cpu_bus_granted_s && acquire_q && !giveback_q;
  endsequence

  sequence s_final_idle;
    final_st && !any_request;
  endsequence

  sequence s_final_busy;
    final_st && any_request;
  endsequence

  sequence s_access;
    first_st || wait_st;
  endsequence

  grant_onehot_a: assert property ($onehot0(~grant_n))
    else $error("More than one grant is active.");

  done_final_a: assert property (!cycle_done_n |-> final_st && $past(ready_s))
    else $error("Cycle done shown outside a ready final state.");

  acquire_set_a: assert property (
    any_request && !ownership_q && !giveback_q && !acquire_q |=> acquire_q)
    else $error("Acquire state not set on a request.");

  grant_load_a: assert property (s_grant_take |=> grant_n == ~$past(pick))
    else $error("Grant register not loaded on hold grant.");

  idle_grants_a: assert property (s_final_idle ##0 !giveback_q
    |=> grant_n == `MDA_GRANT_N_RST)
    else $error("Grants not cleared when no request is pending.");

  load_block_a: assert property (giveback_q |=> $stable(grant_n))
    else $error("Grant register changed during giveback.");

  release_step_a: assert property (s_final_idle |=> !ownership_q && giveback_q)
    else $error("Ownership not handed to giveback.");

  giveback_end_a: assert property (giveback_q && !cpu_bus_granted_s |=> !giveback_q)
    else $error("Giveback not ended after hold grant dropped.");

  hold_own_a: assert property (ownership_q || acquire_q |-> !hold_request_n)
    else $error("Hold request inactive while acquiring or owning.");

  back_to_back_a: assert property (s_final_busy |=> first_st)
    else $error("Memory cycles not run back to back.");

  cycle_stretch_a: assert property (s_access ##0 !ready_s |=> wait_st)
    else $error("Wait state missing while memory not ready.");

  cycle_end_a: assert property (s_access ##0 ready_s |=> final_st ##1 !final_st)
    else $error("Final state not one clock after ready.");

  cycle_flag_a: assert property (!dma_cycle_flag_n |-> s_access)
    else $error("Cycle flag active outside first or wait state.");

  write_pulse_a: assert property (first_st && !rdir_s |-> !write_strobe_n)
    else $error("Write strobe missing for a writing device.");

  reset_state_a: assert property ($past(rst) |-> hold_request_n
    && grant_n == `MDA_GRANT_N_RST && !acquire_q)
    else $error("State not cleared by reset.");

  acquire_clear_a: assert property (acquire_q && cpu_bus_granted_s |=> !acquire_q)
    else $error("Acquire state not cleared on hold grant.");

  acquire_keep_a: assert property (acquire_q && !cpu_bus_granted_s |=> acquire_q)
    else $error("Acquire state lost before hold grant.");

  no_acquire_a: assert property ((ownership_q || giveback_q) && !acquire_q
    |=> !acquire_q)
    else $error("Acquire state set while owning or giving back.");

  own_set_a: assert property (s_grant_take |=> ownership_q)
    else $error("Ownership not set on hold grant.");

  own_keep_a: assert property (ownership_q && !final_st |=> ownership_q)
    else $error("Ownership lost outside a final state.");

  giveback_keep_a: assert property (giveback_q && cpu_bus_granted_s |=> giveback_q)
    else $error("Giveback ended while hold grant still shown.");

  hold_busy_a: assert property ($past(any_request) && !giveback_q
    |-> !hold_request_n)
    else $error("Hold request inactive while a request is pending.");

  hold_idle_a: assert property (!acquire_q && !ownership_q
    && (giveback_q || !$past(any_request)) |-> hold_request_n)
    else $error("Hold request active with nothing to do.");

  hold_release_a: assert property (giveback_q |-> hold_request_n)
    else $error("Hold request active during giveback.");

  giveback_grant_a: assert property (giveback_q |-> grant_n == `MDA_GRANT_N_RST)
    else $error("Grant active during giveback.");

  final_load_a: assert property (final_st |=> grant_n == ~$past(pick))
    else $error("Grant register not loaded at cycle end.");

  load_hold_a: assert property (!grant_load_enable |=> $stable(grant_n))
    else $error("Grant register changed without a load.");

  first_on_grant_a: assert property (cpu_bus_granted_s && acquire_q |=> first_st)
    else $error("First state missing after hold grant.");

  idle_stay_a: assert property (cyc_q == mda_pkg::MDA_CYC_IDLE && !acquire_q
    |=> !first_st)
    else $error("Memory cycle started without acquisition.");

  first_next_a: assert property (first_st |=> final_st || wait_st)
    else $error("First state not followed by wait or final.");

  final_once_a: assert property (final_st |=> !final_st)
    else $error("Final state longer than one clock.");

  wait_entry_a: assert property (wait_st |-> $past(first_st || wait_st))
    else $error("Wait state entered from outside a cycle.");

  done_out_a: assert property (final_st |-> !cycle_done_n)
    else $error("Cycle done missing in final state.");

  done_high_a: assert property (cycle_done_n |-> !final_st)
    else $error("Cycle done inactive in final state.");

  strobe_state_a: assert property (memory_cycle_strobe_n
    == (cyc_q == mda_pkg::MDA_CYC_IDLE))
    else $error("Memory cycle strobe out of step with the cycle.");

  flag_access_a: assert property (first_st || wait_st |-> !dma_cycle_flag_n)
    else $error("Cycle flag missing in first or wait state.");

  write_keep_a: assert property (wait_st && $past(!write_strobe_n)
    |-> !write_strobe_n)
    else $error("Write strobe dropped during a wait state.");

  write_off_a: assert property (!(first_st || wait_st) |-> write_strobe_n)
    else $error("Write strobe active outside first or wait state.");

  read_no_write_a: assert property (first_st && rdir_s |-> write_strobe_n)
    else $error("Write strobe active for a reading device.");
endmodule

/* test/mda_cpu_model.sv */
module mda_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic hold_request_n,
  output logic cpu_bus_granted,
  output logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic gnt_q = 1'b0;
  logic rdy_q = 1'b1;
  logic [1:0] wait_q = 2'h0;
  assign cpu_bus_granted = gnt_q;
  assign mem_ready = rdy_q;
  // The grant is dropped two clocks after hold goes away, so a master that re-requests early collides.
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      gnt_q <= 1'b0;
      wait_q <= 2'h0;
    end
    else if (hold_request_n == gnt_q)
    begin
      if (wait_q == 2'h0)
        gnt_q <= !hold_request_n;
      else
        wait_q <= wait_q - 2'h1;
    end
    else
      wait_q <= gnt_q ? 2'h1 : 2'($urandom_range(2));
  end
  always @(posedge ref_clk)
    rdy_q <= !slow || ($urandom_range(3) != 0);
endmodule

/* test/test_multi_device_dma_arbiter.sv */
`include "mda_map.svh"
module test_multi_device_dma_arbiter;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic jitter = 1'b0;
  logic slow = 1'b0;
  logic we_check = 1'b0;
  logic released = 1'b0;
  logic read_direction = 1'b0;
  logic [7:0] request_n = 8'hFF;
  logic [7:0] keep = 8'h00;
  logic [7:0] last_q = 8'hFF;
  logic [7:0] grant_n;
  logic cpu_bus_granted, mem_ready, cycle_done_n, hold_request_n;
  logic memory_cycle_strobe_n, write_strobe_n, dma_cycle_flag_n;
  logic [7:0] expect_q[$];
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int dones = 0;
  logic en;

  initial forever #5 ref_clk = ~ref_clk;

  mda_arbiter dut (.ref_clk, .rst, .clk_en, .request_n, .cpu_bus_granted, .mem_ready,
    .read_direction, .grant_n, .cycle_done_n, .hold_request_n, .memory_cycle_strobe_n,
    .write_strobe_n, .dma_cycle_flag_n);
  mda_cpu_model cpu (.ref_clk, .rst, .slow, .hold_request_n, .cpu_bus_granted, .mem_ready);

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("mismatches=%0d checked=%0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Devices drop a request once granted, unless told to keep it for a burst.
  task automatic serve();
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge ref_clk);
      request_n <= request_n | (~grant_n & ~keep);
      if (request_n === 8'hFF && hold_request_n === 1'b1 && cpu_bus_granted === 1'b0)
        break;
    end
    #1 check(grant_n, `MDA_GRANT_N_RST);
  endtask

  always @(posedge ref_clk)
    clk_en <= !jitter || ($urandom_range(7) != 0);

  always @(posedge ref_clk)
  begin
    cycles++;
    en = clk_en;
    if (cycles == 20000)
    begin
      mismatches++;
      complete_run();
    end
    #1;
    if (!rst && en)
    begin
      check(8'($countones(~grant_n) <= 1), 8'h01);
      if (memory_cycle_strobe_n === 1'b0 && cycle_done_n === 1'b1)
        check(8'(dma_cycle_flag_n), 8'h00);
      if (cycle_done_n === 1'b0)
      begin
        dones++;
        check(8'(memory_cycle_strobe_n), 8'h00);
        if (we_check)
          check(8'(write_strobe_n), 8'(read_direction));
      end
      if (released && hold_request_n === 1'b0)
        check(8'(cpu_bus_granted), 8'h00);
      if (cpu_bus_granted === 1'b0)
        released <= 1'b0;
      else if (hold_request_n === 1'b1)
        released <= 1'b1;
      if (grant_n !== last_q && grant_n !== `MDA_GRANT_N_RST)
        check(grant_n, expect_q.size() > 0 ? expect_q.pop_front() : 8'hFF);
      last_q <= grant_n;
    end
  end

  initial
  begin
    int n;
    void'($urandom(26849));
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    #1 check(grant_n, `MDA_GRANT_N_RST);
    check({3'h7, hold_request_n, cycle_done_n, memory_cycle_strobe_n, write_strobe_n,
      dma_cycle_flag_n}, 8'hFF);
    @(posedge ref_clk);
    request_n <= 8'hBF;
    expect_q.push_back(8'hBF);
    repeat (2) @(posedge ref_clk);
    #1 check(8'(hold_request_n), 8'h01);
    @(posedge ref_clk);
    #1 check(8'(hold_request_n), 8'h00);
    serve();
    @(posedge ref_clk);
    jitter <= 1'b1;
    slow <= 1'b1;
    request_n <= 8'h00;
    for (int k = 0; k < 8; k++)
      expect_q.push_back(~(8'h01 << k));
    serve();
    // A held request yields back-to-back cycles; the strobe must follow the direction.
    for (int d = 0; d < 2; d++)
    begin
      @(posedge ref_clk);
      read_direction <= d[0];
      keep <= 8'h04 << d;
      request_n <= ~(8'h04 << d);
      expect_q.push_back(~(8'h04 << d));
      we_check <= 1'b1;
      n = dones + 4;
      for (int i = 0; i < 500 && dones < n; i++)
        @(posedge ref_clk);
      keep <= 8'h00;
      serve();
      we_check <= 1'b0;
    end
    @(posedge ref_clk);
    request_n <= 8'hEF;
    expect_q.push_back(8'hEF);
    expect_q.push_back(8'hDF);
    for (int i = 0; i < 500; i++)
    begin
      @(posedge ref_clk);
      if (hold_request_n === 1'b1 && request_n === 8'hFF)
      begin
        request_n <= 8'hDF;
        break;
      end
      request_n <= request_n | ~grant_n;
    end
    for (int i = 0; i < 20 && cpu_bus_granted === 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1 check(grant_n, `MDA_GRANT_N_RST);
      check(8'(hold_request_n), 8'h01);
    end
    serve();
    check(8'(expect_q.size()), 8'h00);
    complete_run();
  end
endmodule
